// *** pkg/timer01_pkg.sv ***
// constants and types shared by the timer 0/1 control block
package timer01_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] RUN_FLAG_IDX = 8'h88;
    localparam logic [7:0] MODE_SEL_IDX = 8'h89;
    localparam logic [7:0] CNT0_LO_IDX = 8'h8a;
    localparam logic [7:0] CNT1_LO_IDX = 8'h8b;
    localparam logic [7:0] CNT0_HI_IDX = 8'h8c;
    localparam logic [7:0] CNT1_HI_IDX = 8'h8d;
    localparam logic [7:0] CLK_SEL_IDX = 8'h8f;
    localparam logic [7:0] IRQ_POL_IDX = 8'h90;
    localparam logic [7:0] T23_CFG_IDX = 8'h91;

    // run and flag control fields
    localparam int OVF1_BIT = 7;
    localparam int RUN1_BIT = 6;
    localparam int OVF0_BIT = 5;
    localparam int RUN0_BIT = 4;
    localparam int XIRQ1_FLAG_BIT = 3;
    localparam int XIRQ1_EDGE_BIT = 2;
    localparam int XIRQ0_FLAG_BIT = 1;
    localparam int XIRQ0_EDGE_BIT = 0;

    // mode select fields
    localparam int GATING_ONE_BIT = 7;
    localparam int CNTSEL_ONE_BIT = 6;
    localparam int MODE_ONE_LSB = 4;
    localparam int GATING_ZERO_BIT = 3;
    localparam int CNTSEL_ZERO_BIT = 2;
    localparam int MODE_ZERO_LSB = 0;

    // clock select fields
    localparam int TMR3_HI_SEL_BIT = 7;
    localparam int TMR3_LO_SEL_BIT = 6;
    localparam int TMR2_HI_SEL_BIT = 5;
    localparam int TMR2_LO_SEL_BIT = 4;
    localparam int CLKSEL_ONE_BIT = 3;
    localparam int CLKSEL_ZERO_BIT = 2;
    localparam int PRESC_LSB = 0;

    // polarity and timer 2/3 config fields
    localparam int POL0_BIT = 0;
    localparam int POL1_BIT = 1;
    localparam int T2_XCLK_BIT = 0;
    localparam int T2_SPLIT_BIT = 1;
    localparam int T3_XCLK_BIT = 2;
    localparam int T3_SPLIT_BIT = 3;

    // 13-bit mode keeps this many low-byte bits
    localparam int LO13_W = 5;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    // idle pin levels: irq and event pins high, external clock low
    localparam logic [4:0] PIN_IDLE = 5'h0f;

    // clock dividers
    localparam int DIV_SYS_A = 12;
    localparam int DIV_SYS_B = 4;
    localparam int DIV_SYS_C = 48;
    localparam int DIV_EXT = 8;
    localparam logic [5:0] DIV_A_LAST = 6'(DIV_SYS_A - 1);
    localparam logic [5:0] DIV_B_LAST = 6'(DIV_SYS_B - 1);
    localparam logic [5:0] DIV_C_LAST = 6'(DIV_SYS_C - 1);
    localparam logic [2:0] DIV_EXT_LAST = 3'(DIV_EXT - 1);

    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_8BIT_RELOAD,
        MODE_SPLIT
    } mode_e;

    typedef enum logic [1:0] {
        PRESC_DIV12,
        PRESC_DIV4,
        PRESC_DIV48,
        PRESC_EXT8
    } presc_e;

endpackage

// *** hw/timer01_ctrl.sv ***
// timer 0/1 control, counting and shared clock selection
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Function
// [RULE_01] timer 1 overflow sets its flag; software or vectoring clears it
// [RULE_02] timer 0 overflow sets its flag; software or vectoring clears it
// [RULE_03] run bits 6 and 4 enable timer 1 and timer 0
// [RULE_04] irq 1 flag: edge sets, vector clears; level mode follows active input
// [RULE_05] irq 0 flag behaves the same as irq 1 flag
// [RULE_06] type bits 2 and 0: zero level, one edge triggered
// [RULE_07] timer 1 gated also needs irq 1 input active
// [RULE_08] timer 0 gated also needs irq 0 input active
// [RULE_09] timer 1 counter select: clock or falling event pin edges
// [RULE_10] timer 0 counter select: clock or falling event pin edges
// [RULE_11] timer 1 modes: 13-bit, 16-bit, 8-bit reload, inactive
// [RULE_12] timer 0 modes: 13-bit, 16-bit, 8-bit reload, split
// [RULE_13] timer 3 high clock select matters only in split mode
// [RULE_14] timer 3 low clock select: system clock or external choice
// [RULE_15] timer 2 high clock select matters only in split mode
// [RULE_16] timer 2 low clock select: system clock or external choice
// [RULE_17] timer 1 clock select ignored when counting; prescaled or system
// [RULE_18] timer 0 clock select ignored when counting; prescaled or system
// [RULE_19] prescaler: sysclk/12, /4, /48, or external clock /8
// [RULE_20] external clock /8 synchronised before use
// [RULE_21] low bytes are read/write, reset to zero
// [RULE_22] 13-bit mode wraps from all ones and sets overflow
// [RULE_23] 8-bit mode reloads low byte from high byte on overflow
// [RULE_24] split mode high byte runs on timer 1 run, sets timer 1 flag
// [RULE_25] pins synchronised; each falling edge counts exactly one
// [RULE_26] hardware flag set wins over a software write
module timer01_ctrl (
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // avalon-mm slave, word addressed
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // external pins
    input wire logic ext_irq_zero_input,
    input wire logic ext_irq_one_input,
    input wire logic timer_zero_event_pin,
    input wire logic timer_one_event_pin,
    input wire logic ext_clk_in,
    // vector acknowledges from the cpu
    input wire logic vector_ack_timer_zero,
    input wire logic vector_ack_timer_one,
    input wire logic vector_ack_irq_zero,
    input wire logic vector_ack_irq_one,
    // flags to the interrupt logic
    output logic timer_zero_overflow_flag,
    output logic timer_one_overflow_flag,
    output logic ext_irq_zero_flag,
    output logic ext_irq_one_flag,
    // clock ticks for timers 2 and 3
    output logic timer_two_low_tick,
    output logic timer_two_high_tick,
    output logic timer_three_low_tick,
    output logic timer_three_high_tick
);
    import timer01_pkg::*;

    // one step of a counter: {overflow, high, low}
    function automatic logic [16:0] step(input mode_e m, input logic [7:0] hi, input logic [7:0] lo);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        s13 = {1'b0, hi, lo[LO13_W-1:0]} + 14'h0001;
        s16 = {1'b0, hi, lo} + 17'h00001;
        s8 = {1'b0, lo} + 9'h001;
        case (m)
            MODE_13BIT: step = {s13[13], s13[12:LO13_W], lo[7:LO13_W], s13[LO13_W-1:0]}; // RULE_22
            MODE_16BIT: step = s16;
            MODE_8BIT_RELOAD: step = {s8[8], hi, s8[8] ? hi : s8[7:0]}; // RULE_23
            default: step = {s8[8], hi, s8[7:0]};
        endcase
    endfunction

    logic [7:0] timer_run_and_flag_control_r, timer_run_and_flag_control_nxt;
    logic [7:0] timer_mode_select_r, timer_clock_select_r, pol_r, cfg_r;
    logic [7:0] tl0_r, tl0_nxt, th0_r, th0_nxt;
    logic [7:0] tl1_r, tl1_nxt, th1_r, th1_nxt;
    logic [4:0] meta_r, sync_r, prev_r;
    logic [5:0] div_a_r, div_b_r, div_c_r;
    logic [2:0] ext_cnt_r;
    logic rd_done_r;
    logic [31:0] readdata_r;
    logic [3:0] tick_r;

    // bus decode; a read takes one wait state
    wire wr_en = write & ce & byteenable[0];
    wire [7:0] wb = writedata[7:0];
    wire wr_timer_run_and_flag_control = wr_en & (address == RUN_FLAG_IDX);
    wire wr_timer_mode_select = wr_en & (address == MODE_SEL_IDX);
    wire wr_tl0 = wr_en & (address == CNT0_LO_IDX); // RULE_21
    wire wr_tl1 = wr_en & (address == CNT1_LO_IDX); // RULE_21
    wire wr_th0 = wr_en & (address == CNT0_HI_IDX);
    wire wr_th1 = wr_en & (address == CNT1_HI_IDX);
    wire wr_ck = wr_en & (address == CLK_SEL_IDX);
    wire wr_pol = wr_en & (address == IRQ_POL_IDX);
    wire wr_cfg = wr_en & (address == T23_CFG_IDX);
    wire rd_take = read & ce & ~rd_done_r;
    assign waitrequest = ~ce | (read & ~rd_done_r);
    assign readdata = readdata_r;

    // read mux; unmapped indices read as zero
    logic [7:0] rd_mux;
    always_comb begin
        case (address)
            RUN_FLAG_IDX: rd_mux = timer_run_and_flag_control_r;
            MODE_SEL_IDX: rd_mux = timer_mode_select_r;
            CNT0_LO_IDX: rd_mux = tl0_r;
            CNT1_LO_IDX: rd_mux = tl1_r;
            CNT0_HI_IDX: rd_mux = th0_r;
            CNT1_HI_IDX: rd_mux = th1_r;
            CLK_SEL_IDX: rd_mux = timer_clock_select_r;
            IRQ_POL_IDX: rd_mux = pol_r;
            T23_CFG_IDX: rd_mux = cfg_r;
            default: rd_mux = RESET_BYTE;
        endcase
    end

    // synchronised pins: 0 irq0, 1 irq1, 2 ev0, 3 ev1, 4 ext clock
    wire [4:0] pins = {ext_clk_in, timer_one_event_pin, timer_zero_event_pin,
                       ext_irq_one_input, ext_irq_zero_input};
    wire ext_irq_zero_input_act = sync_r[0] == pol_r[POL0_BIT];
    wire ext_irq_one_input_act = sync_r[1] == pol_r[POL1_BIT];
    wire ext_irq_zero_input_was = prev_r[0] == pol_r[POL0_BIT];
    wire ext_irq_one_input_was = prev_r[1] == pol_r[POL1_BIT];
    wire ext_irq_zero_input_edge = ext_irq_zero_input_act & ~ext_irq_zero_input_was;
    wire ext_irq_one_input_edge = ext_irq_one_input_act & ~ext_irq_one_input_was;
    wire ev0_fall = prev_r[2] & ~sync_r[2]; // RULE_25
    wire ev1_fall = prev_r[3] & ~sync_r[3]; // RULE_25
    wire ext_rise = sync_r[4] & ~prev_r[4];

    // prescaler ticks, all qualified by the enable
    wire div_a_tick = ce & (div_a_r == DIV_A_LAST);
    wire div_b_tick = ce & (div_b_r == DIV_B_LAST);
    wire div_c_tick = ce & (div_c_r == DIV_C_LAST);
    wire ext8_tick = ce & ext_rise & (ext_cnt_r == DIV_EXT_LAST); // RULE_20
    logic presc_tick;
    always_comb begin
        case (presc_e'(timer_clock_select_r[PRESC_LSB+:2])) // RULE_19
            PRESC_DIV12: presc_tick = div_a_tick;
            PRESC_DIV4: presc_tick = div_b_tick;
            PRESC_DIV48: presc_tick = div_c_tick;
            default: presc_tick = ext8_tick;
        endcase
    end

    // timer 0 sources and run
    mode_e mode0, mode1;
    assign mode0 = mode_e'(timer_mode_select_r[MODE_ZERO_LSB+:2]);
    assign mode1 = mode_e'(timer_mode_select_r[MODE_ONE_LSB+:2]);
    wire split0 = mode0 == MODE_SPLIT; // RULE_12
    wire int_clk0 = timer_clock_select_r[CLKSEL_ZERO_BIT] ? ce : presc_tick; // RULE_18
    wire int_clk1 = timer_clock_select_r[CLKSEL_ONE_BIT] ? ce : presc_tick; // RULE_17
    wire src0 = timer_mode_select_r[CNTSEL_ZERO_BIT] ? (ce & ev0_fall) : int_clk0; // RULE_10
    wire run0 = timer_run_and_flag_control_r[RUN0_BIT] & (~timer_mode_select_r[GATING_ZERO_BIT] | ext_irq_zero_input_act); // RULE_03 RULE_08
    wire inc0 = run0 & src0;
    wire inc0h = split0 & timer_run_and_flag_control_r[RUN1_BIT] & int_clk0; // RULE_24

    // timer 1: split timer 0 takes its run bit and flag; timer 1 then runs ungated on its clock, not its pin
    wire src1 = (timer_mode_select_r[CNTSEL_ONE_BIT] & ~split0) ? (ce & ev1_fall) : int_clk1; // RULE_09
    wire run1_n = timer_run_and_flag_control_r[RUN1_BIT] & (~timer_mode_select_r[GATING_ONE_BIT] | ext_irq_one_input_act); // RULE_07
    wire run1 = (mode1 != MODE_SPLIT) & (split0 | run1_n); // RULE_11
    wire inc1 = run1 & src1;

    wire [16:0] nx0 = step(mode0, th0_r, tl0_r);
    wire [16:0] nx0h = step(MODE_SPLIT, RESET_BYTE, th0_r);
    wire [16:0] nx1 = step(mode1, th1_r, tl1_r);
    wire ovf0 = inc0 & nx0[16];
    wire ovf0h = inc0h & nx0h[16];
    wire ovf1 = inc1 & nx1[16] & ~split0;
    wire set_f0 = ovf0; // RULE_02
    wire set_f1 = ovf1 | ovf0h; // RULE_01 RULE_24

    // counter next values; a software write replaces the count
    assign tl0_nxt = wr_tl0 ? wb : (inc0 ? nx0[7:0] : tl0_r);
    assign th0_nxt = wr_th0 ? wb : (inc0h ? nx0h[7:0] : ((inc0 & ~split0) ? nx0[15:8] : th0_r));
    assign tl1_nxt = wr_tl1 ? wb : (inc1 ? nx1[7:0] : tl1_r);
    assign th1_nxt = wr_th1 ? wb : (inc1 ? nx1[15:8] : th1_r);

    // flag register; hardware sets beat clears so no event is lost
    logic [7:0] tc_base;
    always_comb begin
        tc_base = wr_timer_run_and_flag_control ? wb : timer_run_and_flag_control_r;
        timer_run_and_flag_control_nxt = tc_base;
        timer_run_and_flag_control_nxt[OVF1_BIT] = (tc_base[OVF1_BIT] & ~vector_ack_timer_one) | set_f1; // RULE_01 RULE_26
        timer_run_and_flag_control_nxt[OVF0_BIT] = (tc_base[OVF0_BIT] & ~vector_ack_timer_zero) | set_f0; // RULE_02 RULE_26
        if (tc_base[XIRQ1_EDGE_BIT]) begin // RULE_06
            timer_run_and_flag_control_nxt[XIRQ1_FLAG_BIT] = (tc_base[XIRQ1_FLAG_BIT] & ~vector_ack_irq_one) | ext_irq_one_input_edge; // RULE_04
        end else begin
            timer_run_and_flag_control_nxt[XIRQ1_FLAG_BIT] = ext_irq_one_input_act; // RULE_04
        end
        if (tc_base[XIRQ0_EDGE_BIT]) begin // RULE_06
            timer_run_and_flag_control_nxt[XIRQ0_FLAG_BIT] = (tc_base[XIRQ0_FLAG_BIT] & ~vector_ack_irq_zero) | ext_irq_zero_input_edge; // RULE_05
        end else begin
            timer_run_and_flag_control_nxt[XIRQ0_FLAG_BIT] = ext_irq_zero_input_act; // RULE_05
        end
    end

    // timer 2/3 clock choice; high select only counts in split mode
    wire t2_ext = cfg_r[T2_XCLK_BIT] ? ext8_tick : div_a_tick;
    wire t3_ext = cfg_r[T3_XCLK_BIT] ? ext8_tick : div_a_tick;
    wire t2_lo = timer_clock_select_r[TMR2_LO_SEL_BIT] ? ce : t2_ext; // RULE_16
    wire t3_lo = timer_clock_select_r[TMR3_LO_SEL_BIT] ? ce : t3_ext; // RULE_14
    wire t2_hi = ~cfg_r[T2_SPLIT_BIT] ? t2_lo : (timer_clock_select_r[TMR2_HI_SEL_BIT] ? ce : t2_ext); // RULE_15
    wire t3_hi = ~cfg_r[T3_SPLIT_BIT] ? t3_lo : (timer_clock_select_r[TMR3_HI_SEL_BIT] ? ce : t3_ext); // RULE_13

    // two-flop synchronisers plus one history stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= PIN_IDLE; // idle levels, so no false edge or level after reset
            sync_r <= PIN_IDLE;
            prev_r <= PIN_IDLE;
        end else if (ce) begin
            meta_r <= pins; // RULE_25
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // dividers; the /48 is free running so ratios stay exact
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_a_r <= 6'h00;
            div_b_r <= 6'h00;
            div_c_r <= 6'h00;
            ext_cnt_r <= 3'h0;
        end else if (ce) begin
            div_a_r <= div_a_tick ? 6'h00 : div_a_r + 6'h01;
            div_b_r <= div_b_tick ? 6'h00 : div_b_r + 6'h01;
            div_c_r <= div_c_tick ? 6'h00 : div_c_r + 6'h01;
            if (ext_rise) begin
                ext_cnt_r <= ext_cnt_r + 3'h1; // RULE_20
            end
        end
    end

    // configuration registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_mode_select_r <= RESET_BYTE;
            timer_clock_select_r <= RESET_BYTE;
            pol_r <= RESET_BYTE;
            cfg_r <= RESET_BYTE;
        end else begin
            if (wr_timer_mode_select) timer_mode_select_r <= wb;
            if (wr_ck) timer_clock_select_r <= wb;
            if (wr_pol) pol_r <= {6'h00, wb[1:0]};
            if (wr_cfg) cfg_r <= {4'h0, wb[3:0]};
        end
    end

    // counters and flags
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_run_and_flag_control_r <= RESET_BYTE;
            tl0_r <= RESET_BYTE; // RULE_21
            th0_r <= RESET_BYTE;
            tl1_r <= RESET_BYTE; // RULE_21
            th1_r <= RESET_BYTE;
        end else if (ce) begin
            timer_run_and_flag_control_r <= timer_run_and_flag_control_nxt;
            tl0_r <= tl0_nxt;
            th0_r <= th0_nxt;
            tl1_r <= tl1_nxt;
            th1_r <= th1_nxt;
        end
    end

    // bus answer and registered tick outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_done_r <= 1'b0;
            readdata_r <= 32'h0000_0000;
            tick_r <= 4'h0;
        end else if (ce) begin
            rd_done_r <= rd_take;
            if (rd_take) readdata_r <= {24'h00_0000, rd_mux};
            tick_r <= {t3_hi, t3_lo, t2_hi, t2_lo};
        end
    end

    assign timer_zero_overflow_flag = timer_run_and_flag_control_r[OVF0_BIT];
    assign timer_one_overflow_flag = timer_run_and_flag_control_r[OVF1_BIT];
    assign ext_irq_zero_flag = timer_run_and_flag_control_r[XIRQ0_FLAG_BIT];
    assign ext_irq_one_flag = timer_run_and_flag_control_r[XIRQ1_FLAG_BIT];
    assign timer_two_low_tick = tick_r[0];
    assign timer_two_high_tick = tick_r[1];
    assign timer_three_low_tick = tick_r[2];
    assign timer_three_high_tick = tick_r[3];

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_ovf0_sets;
        ce && set_f0 |=> timer_run_and_flag_control_r[OVF0_BIT];
    endproperty
    a_ovf0_sets: assert property (p_ovf0_sets) else $error("timer 0 overflow lost"); // RULE_02

    property p_ack1_clears;
        ce && vector_ack_timer_one && !set_f1 |=> !timer_run_and_flag_control_r[OVF1_BIT];
    endproperty
    a_ack1_clears: assert property (p_ack1_clears) else $error("timer 1 flag not cleared"); // RULE_01

    property p_stop_holds;
        ce && !timer_run_and_flag_control_r[RUN0_BIT] && !wr_tl0 |=> $stable(tl0_r);
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("stopped timer 0 moved"); // RULE_03

    property p_gate_holds;
        ce && timer_mode_select_r[GATING_ZERO_BIT] && !ext_irq_zero_input_act && !wr_tl0 |=> $stable(tl0_r);
    endproperty
    a_gate_holds: assert property (p_gate_holds) else $error("gated timer 0 moved"); // RULE_08

    property p_level_follow;
        ce && !timer_run_and_flag_control_nxt[XIRQ0_EDGE_BIT] |=> ext_irq_zero_flag == $past(ext_irq_zero_input_act);
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("level irq 0 flag wrong"); // RULE_05

    property p_reload;
        ce && mode0 == MODE_8BIT_RELOAD && inc0 && tl0_r == 8'hff && !wr_tl0 && !wr_th0
            |=> tl0_r == $past(th0_r) && timer_run_and_flag_control_r[OVF0_BIT];
    endproperty
    a_reload: assert property (p_reload) else $error("8-bit reload wrong"); // RULE_23

    property p_count_one;
        ce && mode0 == MODE_16BIT && timer_mode_select_r[CNTSEL_ZERO_BIT] && run0 && ev0_fall && !wr_en
            |=> {th0_r, tl0_r} == $past({th0_r, tl0_r}) + 16'h0001;
    endproperty
    a_count_one: assert property (p_count_one) else $error("event not counted once"); // RULE_25

    property p_set_wins;
        ce && set_f0 && wr_timer_run_and_flag_control && !wb[OVF0_BIT] |=> timer_run_and_flag_control_r[OVF0_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag set lost to write"); // RULE_26

    property p_div4;
        presc_tick && timer_clock_select_r[PRESC_LSB+:2] == 2'h1 ##1 ce [*3] ##1 ce |-> div_b_tick;
    endproperty
    a_div4: assert property (p_div4) else $error("divide by 4 spacing wrong"); // RULE_19

    property p_ext8;
        ext8_tick |-> ext_rise && ext_cnt_r == DIV_EXT_LAST;
    endproperty
    a_ext8: assert property (p_ext8) else $error("ext divide without edge"); // RULE_20

    property p_split_flag;
        ce && ovf0h |=> timer_run_and_flag_control_r[OVF1_BIT];
    endproperty
    a_split_flag: assert property (p_split_flag) else $error("split high overflow lost"); // RULE_24

    property p_timer_one_off;
        ce && mode1 == MODE_SPLIT && !wr_tl1 && !wr_th1 |=> $stable({th1_r, tl1_r});
    endproperty
    a_timer_one_off: assert property (p_timer_one_off) else $error("timer 1 ran in mode 3"); // RULE_11

    c_ovf0: cover property (ce && ovf0);
    c_reload: cover property (ce && mode0 == MODE_8BIT_RELOAD && ovf0);
    c_split: cover property (ce && ovf0h);
    c_edge_irq: cover property (ce && ext_irq_one_input_edge && timer_run_and_flag_control_r[XIRQ1_EDGE_BIT]);

endmodule
`default_nettype wire

// *** dv/timer01_pins_model.sv ***
// pin and cpu-side model facing the timer 0/1 block
`timescale 1ns/1ps
`default_nettype none
module timer01_pins_model (
    // clock
    input wire logic clk,
    // pins toward the block, idle high except the external clock, which starts low
    output logic ext_irq_zero_input,
    output logic ext_irq_one_input,
    output logic timer_zero_event_pin,
    output logic timer_one_event_pin,
    output logic ext_clk_in,
    // vector acks: timer0, timer1, irq0, irq1
    output logic [3:0] vec_ack
);
    // oscillator runs free, phase unrelated to clk
    initial begin
        ext_irq_zero_input = 1'b1;
        ext_irq_one_input = 1'b1;
        timer_zero_event_pin = 1'b1;
        timer_one_event_pin = 1'b1;
        vec_ack = 4'h0;
        ext_clk_in = 1'b0;
        #1.3;
        forever #10 ext_clk_in = ~ext_clk_in;
    end

    // each level held three cycles, above the two-cycle sampling floor
    task automatic pulse(input int pin, input int n);
        repeat (n) begin
            if (pin == 0) timer_zero_event_pin <= 1'b0;
            else timer_one_event_pin <= 1'b0;
            repeat (3) @(posedge clk);
            if (pin == 0) timer_zero_event_pin <= 1'b1;
            else timer_one_event_pin <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask

    // level changes settle through the synchroniser before returning
    task automatic set_irq(input int idx, input logic lvl);
        if (idx == 0) ext_irq_zero_input <= lvl;
        else ext_irq_one_input <= lvl;
        repeat (5) @(posedge clk);
    endtask

    // one-cycle vector pulse, as the cpu gives it
    task automatic ack(input int idx);
        vec_ack[idx] <= 1'b1;
        @(posedge clk);
        vec_ack[idx] <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** dv/test_timer01_control_and_clock_select.sv ***
// self-checking bench for the timer 0/1 control block
`timescale 1ns/1ps
`default_nettype none
module test_timer01_control_and_clock_select;
    import timer01_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq0, irq1, ev0, ev1, xclk;
    logic [3:0] vack;
    logic [3:0] ticks;
    logic [3:0] flags;
    logic [7:0] et, fl;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] regs [5] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8f};
    logic [7:0] ck [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04};
    int ex [5] = '{20, 60, 5, 6, 240};

    // 250 MHz
    always #2 clk = ~clk;

    timer01_ctrl u_dut (.clk(clk), .arst_n(arst_n), .ce(1'b1), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
        .waitrequest(waitrequest), .ext_irq_zero_input(irq0), .ext_irq_one_input(irq1),
        .timer_zero_event_pin(ev0), .timer_one_event_pin(ev1), .ext_clk_in(xclk),
        .vector_ack_timer_zero(vack[0]), .vector_ack_timer_one(vack[1]),
        .vector_ack_irq_zero(vack[2]), .vector_ack_irq_one(vack[3]),
        .timer_zero_overflow_flag(flags[0]), .timer_one_overflow_flag(flags[1]), .ext_irq_zero_flag(flags[2]),
        .ext_irq_one_flag(flags[3]), .timer_two_low_tick(ticks[0]), .timer_two_high_tick(ticks[1]),
        .timer_three_low_tick(ticks[2]), .timer_three_high_tick(ticks[3]));

    timer01_pins_model u_pins (.clk(clk), .ext_irq_zero_input(irq0), .ext_irq_one_input(irq1),
        .timer_zero_event_pin(ev0), .timer_one_event_pin(ev1), .ext_clk_in(xclk), .vec_ack(vack));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one avalon cycle; an extra edge after release keeps requests apart
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= !wr;
        // only the bench's hang guard bounds this wait
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        check(q & m, exp);
    endtask

    // prescaler phase is unknown, so a count may land a tick either side
    task automatic near(input logic [7:0] a, input int exp, input int tol);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        check(q, ((int'(q) - exp) <= tol && (exp - int'(q)) <= tol) ? q : 8'(exp));
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        foreach (regs[i]) rd_chk(regs[i], 8'hff, 8'h00);
        rd_chk(8'h00, 8'hff, 8'h00);
        wr(CNT1_LO_IDX, 8'ha5);
        rd_chk(CNT1_LO_IDX, 8'hff, 8'ha5);
        // event counting, run off then on, then gated
        wr(MODE_SEL_IDX, 8'h05);
        wr(CNT0_LO_IDX, 8'h00);
        u_pins.pulse(0, 2);
        rd_chk(CNT0_LO_IDX, 8'hff, 8'h00);
        wr(RUN_FLAG_IDX, 8'h10);
        u_pins.pulse(0, 3);
        rd_chk(CNT0_LO_IDX, 8'hff, 8'h03);
        wr(MODE_SEL_IDX, 8'h0d);
        u_pins.pulse(0, 2);
        rd_chk(CNT0_LO_IDX, 8'hff, 8'h03);
        u_pins.set_irq(0, 1'b0);
        u_pins.pulse(0, 2);
        rd_chk(CNT0_LO_IDX, 8'hff, 8'h05);
        u_pins.set_irq(0, 1'b1);
        // 8-bit reload through the wrap
        wr(MODE_SEL_IDX, 8'h06);
        wr(CNT0_HI_IDX, 8'hf0);
        wr(CNT0_LO_IDX, 8'hfe);
        u_pins.pulse(0, 3);
        rd_chk(CNT0_LO_IDX, 8'hff, 8'hf1);
        rd_chk(CNT0_HI_IDX, 8'hff, 8'hf0);
        rd_chk(RUN_FLAG_IDX, 8'h30, 8'h30);
        check({4'h0, flags}, 8'h01);
        u_pins.ack(0);
        rd_chk(RUN_FLAG_IDX, 8'h30, 8'h10);
        // 13-bit timer 1 on its event pin
        wr(MODE_SEL_IDX, 8'h40);
        wr(CNT1_HI_IDX, 8'hff);
        wr(CNT1_LO_IDX, 8'h1e);
        wr(RUN_FLAG_IDX, 8'h40);
        u_pins.pulse(1, 1);
        rd_chk(RUN_FLAG_IDX, 8'hc0, 8'h40);
        u_pins.pulse(1, 1);
        rd_chk(CNT1_LO_IDX, 8'h1f, 8'h00);
        rd_chk(RUN_FLAG_IDX, 8'hc0, 8'hc0);
        wr(RUN_FLAG_IDX, 8'h40);
        rd_chk(RUN_FLAG_IDX, 8'hc0, 8'h40);
        // split mode: high byte on /48 sets the timer 1 flag
        wr(CNT0_HI_IDX, 8'hfd);
        wr(CLK_SEL_IDX, 8'h02);
        wr(MODE_SEL_IDX, 8'h03);
        repeat (200) @(posedge clk);
        rd_chk(RUN_FLAG_IDX, 8'h80, 8'h80);
        u_pins.ack(1);
        rd_chk(RUN_FLAG_IDX, 8'h80, 8'h00);
        // prescaler choices and system clock, 16-bit timer 0
        wr(MODE_SEL_IDX, 8'h01);
        for (int i = 0; i < 5; i++) begin
            wr(CNT0_LO_IDX, 8'h00);
            wr(CLK_SEL_IDX, ck[i]);
            wr(RUN_FLAG_IDX, 8'h10);
            repeat (238) @(posedge clk);
            wr(RUN_FLAG_IDX, 8'h00);
            near(CNT0_LO_IDX, ex[i], 2);
        end
        // external interrupts, edge then level
        wr(MODE_SEL_IDX, 8'h00);
        for (int i = 0; i < 2; i++) begin
            et = 8'h01 << (2 * i);
            fl = 8'h02 << (2 * i);
            wr(RUN_FLAG_IDX, et);
            u_pins.set_irq(i, 1'b0);
            rd_chk(RUN_FLAG_IDX, 8'h0f, et | fl);
            check({4'h0, flags}, 8'h04 << i);
            u_pins.ack(2 + i);
            rd_chk(RUN_FLAG_IDX, 8'h0f, et);
            wr(RUN_FLAG_IDX, 8'h00);
            rd_chk(RUN_FLAG_IDX, 8'h0f, fl);
            u_pins.set_irq(i, 1'b1);
            rd_chk(RUN_FLAG_IDX, 8'h0f, 8'h00);
        end
        // timer 2/3 ticks; high selects ignored outside split
        wr(CLK_SEL_IDX, 8'hf0);
        repeat (3) @(posedge clk);
        #1;
        check({4'h0, ticks}, 8'h0f);
        @(posedge clk);
        wr(CLK_SEL_IDX, 8'h50);
        repeat (3) @(posedge clk);
        #1;
        check({4'h0, ticks}, 8'h0f);
        @(posedge clk);
        print_verdict();
    end
endmodule
`default_nettype wire
